// ===== core/adc_capture_consts.vh
`ifndef ADC_CAPTURE_CONSTS_VH
`define ADC_CAPTURE_CONSTS_VH

// register map (byte addresses on the serial bus)
`define REG_CONTROL        8'h20
`define REG_RESULT_LO      8'h21
`define REG_RESULT_HI      8'h22

// control register layout
`define CONTROL_RESET      8'h32
`define CTL_MODE_BIT       7
`define CTL_TRIG_BIT       6
`define CTL_RATE_HI        5
`define CTL_RATE_LO        4
`define CTL_ARM_BIT        3
`define CTL_LOCK_HI        2
`define CTL_LOCK_LO        1
`define CTL_PORT_BIT       0
`define LOCK_UNLOCK_CODE   2'h1
`define LOCK_READ_ON       2'h0
`define LOCK_READ_OFF      2'h1
`define RATE_RESET         2'h3

// result register
`define RESULT_RESET       16'h0000
`define RESULT_BITS        12

// serial device address, arbitrary value
`define DEV_ADDR           7'h2c

// clock and sample periods
`define MCLK_PERIOD_NS     50
`define RATE0_PERIOD_NS    100000
`define RATE1_PERIOD_NS    80000
`define RATE2_PERIOD_NS    66666
`define RATE3_PERIOD_NS    50000
// sample periods in clock cycles, pacer width
`define RATE0_CYC          11'h7d0
`define RATE1_CYC          11'h640
`define RATE2_CYC          11'h535
`define RATE3_CYC          11'h3e8
`define PACER_WIDTH        11

`endif

// ===== core/adc_capture_control.v
`timescale 1ns/1ps
`include "adc_capture_consts.vh"
`default_nettype none
module adc_capture_control (
   // clock and reset
   input  wire        MCLK,
   input  wire        SRST,
   // serial register bus
   input  wire        SCL,
   input  wire        SDA_IN,
   output reg         SDA_OUT,
   output reg         SDA_OE,
   // converter
   output reg         CONV_START,
   output reg         CONV_PORT,
   input  wire        CONV_DONE,
   input  wire [11:0] CONV_DATA,
   // charge pump and touch panel function
   output reg         PUMP_ON,
   output reg  [1:0]  TOUCH_RATE_LIMIT,
   // one-shot completion events
   output reg         IRQ_PORT0,
   output reg         IRQ_PORT1
);

   localparam S_IDLE  = 4'h0;
   localparam S_ADDR  = 4'h1;
   localparam S_ACK_A = 4'h2;
   localparam S_PTR   = 4'h3;
   localparam S_ACK_P = 4'h4;
   localparam S_WDATA = 4'h5;
   localparam S_ACK_W = 4'h6;
   localparam S_RDATA = 4'h7;
   localparam S_RACK  = 4'h8;

   wire        scl_f;
   wire        sda_f;
   reg         scl_d_r;
   reg         sda_d_r;
   reg  [3:0]  state_r;
   reg  [3:0]  cnt_r;
   reg  [7:0]  shift_r;
   reg  [7:0]  out_r;
   reg  [7:0]  ptr_r;
   reg         rw_r;
   reg         nack_r;
   // control state
   reg         mode_r;
   reg         trig_r;
   reg         arm_r;
   reg         arm_new_r;
   reg         busy_r;
   reg         shot_r;
   // result state
   reg  [15:0] live_r;
   reg  [15:0] snap_r;
   reg         frozen_r;
   reg         lo_done_r;
   reg         hi_done_r;
   wire        tick;
   wire        scl_rise = scl_f & ~scl_d_r;
   wire        scl_fall = ~scl_f & scl_d_r;
   wire        start_c  = scl_f & scl_d_r & sda_d_r & ~sda_f;
   wire        stop_c   = scl_f & scl_d_r & ~sda_d_r & sda_f;
   wire [7:0]  byte_in  = shift_r;
   wire        is_result_ptr = (ptr_r == `REG_RESULT_LO) || (ptr_r == `REG_RESULT_HI);

   pin_filter u_scl (
      .clk   (MCLK),
      .rst   (SRST),
      .pin   (SCL),
      .level (scl_f)
   );

   pin_filter u_sda (
      .clk   (MCLK),
      .rst   (SRST),
      .pin   (SDA_IN),
      .level (sda_f)
   );

   sample_pacer u_pacer (
      .clk    (MCLK),
      .rst    (SRST),
      .enable (trig_r & ~mode_r),
      .rate   (TOUCH_RATE_LIMIT),
      .tick   (tick)
   );

   function [7:0] control_view;
      input       mode;
      input       trig;
      input [1:0] rate;
      input       arm;
      input       pump;
      input       port;
      begin
         control_view = {mode, trig, rate, arm,
                         pump ? `LOCK_READ_ON : `LOCK_READ_OFF, port};
      end
   endfunction

   function [7:0] result_byte;
      input [15:0] word;
      input        hi;
      begin
         result_byte = hi ? word[15:8] : word[7:0];
      end
   endfunction

   // one control write, including pump sequencing
   task control_write;
      input [7:0] w;
      begin
         mode_r           <= w[`CTL_MODE_BIT];
         TOUCH_RATE_LIMIT <= w[`CTL_RATE_HI:`CTL_RATE_LO];
         CONV_PORT        <= w[`CTL_PORT_BIT];
         if (w[`CTL_MODE_BIT]) begin
            if (w[`CTL_TRIG_BIT] && !busy_r) begin
               trig_r <= 1'b1;
            end
         end else begin
            trig_r <= w[`CTL_TRIG_BIT];
         end
         if (!arm_r) begin
            arm_r     <= w[`CTL_ARM_BIT];
            arm_new_r <= w[`CTL_ARM_BIT];
         end else if (arm_new_r) begin
            arm_r <= w[`CTL_ARM_BIT];
         end else if (w[`CTL_LOCK_HI:`CTL_LOCK_LO] == `LOCK_UNLOCK_CODE) begin
            PUMP_ON <= 1'b1;
            arm_r   <= w[`CTL_ARM_BIT];
         end else begin
            arm_r <= 1'b0;
         end
      end
   endtask

   always @(posedge MCLK) begin
      if (SRST) begin
         scl_d_r          <= 1'b1;
         sda_d_r          <= 1'b1;
         state_r          <= S_IDLE;
         cnt_r            <= 4'h0;
         shift_r          <= 8'h00;
         out_r            <= 8'h00;
         ptr_r            <= 8'h00;
         rw_r             <= 1'b0;
         nack_r           <= 1'b0;
         SDA_OUT          <= 1'b0;
         SDA_OE           <= 1'b0;
         mode_r           <= 1'b0;
         trig_r           <= 1'b0;
         TOUCH_RATE_LIMIT <= `RATE_RESET;
         arm_r            <= 1'b0;
         arm_new_r        <= 1'b0;
         PUMP_ON          <= 1'b0;
         CONV_PORT        <= 1'b0;
         busy_r           <= 1'b0;
         shot_r           <= 1'b0;
         CONV_START       <= 1'b0;
         IRQ_PORT0        <= 1'b0;
         IRQ_PORT1        <= 1'b0;
         live_r           <= `RESULT_RESET;
         snap_r           <= `RESULT_RESET;
         frozen_r         <= 1'b0;
         lo_done_r        <= 1'b0;
         hi_done_r        <= 1'b0;
      end else begin
         scl_d_r    <= scl_f;
         sda_d_r    <= sda_f;
         SDA_OUT    <= 1'b0;
         CONV_START <= 1'b0;
         IRQ_PORT0  <= 1'b0;
         IRQ_PORT1  <= 1'b0;

         // conversion sequencing
         if (!busy_r && (tick || (mode_r && trig_r && !shot_r))) begin
            CONV_START <= 1'b1;
            busy_r     <= 1'b1;
            shot_r     <= mode_r;
         end
         if (busy_r && CONV_DONE) begin
            busy_r <= 1'b0;
            live_r <= {4'h0, CONV_DATA[`RESULT_BITS-1:0]};
            if (shot_r) begin
               shot_r    <= 1'b0;
               trig_r    <= 1'b0;
               IRQ_PORT0 <= ~CONV_PORT;
               IRQ_PORT1 <= CONV_PORT;
            end
         end

         // both result bytes taken: release the snapshot
         if (frozen_r && lo_done_r && hi_done_r) begin
            frozen_r  <= 1'b0;
            lo_done_r <= 1'b0;
            hi_done_r <= 1'b0;
         end

         if (start_c) begin
            state_r   <= S_ADDR;
            cnt_r     <= 4'h0;
            SDA_OE    <= 1'b0;
            arm_new_r <= 1'b0;
         end else if (stop_c) begin
            state_r   <= S_IDLE;
            SDA_OE    <= 1'b0;
            arm_new_r <= 1'b0;
         end else if (scl_rise) begin
            case (state_r)
               S_ADDR, S_PTR, S_WDATA: begin
                  shift_r <= {shift_r[6:0], sda_f};
                  cnt_r   <= cnt_r + 4'h1;
               end
               S_RDATA: begin
                  cnt_r <= cnt_r + 4'h1;
               end
               S_RACK: begin
                  nack_r <= sda_f;
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (state_r)
               S_ADDR: begin
                  if (cnt_r == 4'h8) begin
                     cnt_r <= 4'h0;
                     if (byte_in[7:1] == `DEV_ADDR) begin
                        rw_r    <= byte_in[0];
                        SDA_OE  <= 1'b1;
                        state_r <= S_ACK_A;
                     end else begin
                        state_r <= S_IDLE;
                     end
                  end
               end
               S_ACK_A, S_RACK: begin
                  cnt_r <= 4'h0;
                  if ((state_r == S_RACK) && nack_r) begin
                     state_r <= S_IDLE;
                     SDA_OE  <= 1'b0;
                  end else if (rw_r) begin
                     state_r <= S_RDATA;
                     if (is_result_ptr) begin
                        if (!frozen_r) begin
                           snap_r   <= live_r;
                           frozen_r <= 1'b1;
                           out_r    <= result_byte(live_r, ptr_r == `REG_RESULT_HI);
                           SDA_OE   <= ~((ptr_r == `REG_RESULT_HI) ? live_r[15] : live_r[7]);
                        end else begin
                           out_r  <= result_byte(snap_r, ptr_r == `REG_RESULT_HI);
                           SDA_OE <= ~((ptr_r == `REG_RESULT_HI) ? snap_r[15] : snap_r[7]);
                        end
                        lo_done_r <= lo_done_r | (ptr_r == `REG_RESULT_LO);
                        hi_done_r <= hi_done_r | (ptr_r == `REG_RESULT_HI);
                     end else begin
                        frozen_r  <= 1'b0;
                        lo_done_r <= 1'b0;
                        hi_done_r <= 1'b0;
                        if (ptr_r == `REG_CONTROL) begin
                           out_r  <= control_view(mode_r, trig_r, TOUCH_RATE_LIMIT, arm_r, PUMP_ON, CONV_PORT);
                           SDA_OE <= ~mode_r;
                        end else begin
                           out_r  <= 8'h00;
                           SDA_OE <= 1'b1;
                        end
                     end
                  end else begin
                     SDA_OE  <= 1'b0;
                     state_r <= S_PTR;
                  end
               end
               S_PTR: begin
                  if (cnt_r == 4'h8) begin
                     cnt_r   <= 4'h0;
                     ptr_r   <= byte_in;
                     SDA_OE  <= 1'b1;
                     state_r <= S_ACK_P;
                     if ((byte_in != `REG_RESULT_LO) && (byte_in != `REG_RESULT_HI)) begin
                        frozen_r  <= 1'b0;
                        lo_done_r <= 1'b0;
                        hi_done_r <= 1'b0;
                     end
                  end
               end
               S_ACK_P, S_ACK_W: begin
                  SDA_OE  <= 1'b0;
                  state_r <= S_WDATA;
               end
               S_WDATA: begin
                  if (cnt_r == 4'h8) begin
                     cnt_r   <= 4'h0;
                     SDA_OE  <= 1'b1;
                     state_r <= S_ACK_W;
                     ptr_r   <= ptr_r + 8'h01;
                     if (ptr_r == `REG_CONTROL) begin
                        control_write(byte_in);
                     end
                  end
               end
               S_RDATA: begin
                  if (cnt_r == 4'h8) begin
                     SDA_OE  <= 1'b0;
                     state_r <= S_RACK;
                     ptr_r   <= ptr_r + 8'h01;
                  end else begin
                     out_r  <= {out_r[6:0], 1'b0};
                     SDA_OE <= ~out_r[6];
                  end
               end
               default: begin
                  SDA_OE <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ===== core/pin_filter.v
`timescale 1ns/1ps
`default_nettype none
module pin_filter (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // pin and filtered level
   input  wire       pin,
   output reg        level
);

   reg s1_r;
   reg s2_r;
   reg s3_r;

   always @(posedge clk) begin
      if (rst) begin
         s1_r  <= 1'b1;
         s2_r  <= 1'b1;
         s3_r  <= 1'b1;
         level <= 1'b1;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // change accepted once second and third stage agree
         if (s2_r == s3_r) begin
            level <= s3_r;
         end
      end
   end

endmodule
`default_nettype wire

// ===== core/sample_pacer.v
`timescale 1ns/1ps
`include "adc_capture_consts.vh"
`default_nettype none
module sample_pacer (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // control
   input  wire       enable,
   input  wire [1:0] rate,
   // one pulse per sample period
   output reg        tick
);

   reg [`PACER_WIDTH-1:0] count_r;

   function [`PACER_WIDTH-1:0] period_of;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    period_of = `RATE0_CYC;
            2'h1:    period_of = `RATE1_CYC;
            2'h2:    period_of = `RATE2_CYC;
            default: period_of = `RATE3_CYC;
         endcase
      end
   endfunction

   always @(posedge clk) begin
      if (rst) begin
         count_r <= {`PACER_WIDTH{1'b0}};
         tick    <= 1'b0;
      end else if (!enable) begin
         count_r <= {`PACER_WIDTH{1'b0}};
         tick    <= 1'b0;
      end else begin
         // first sample right away, then one per period
         tick <= (count_r == {`PACER_WIDTH{1'b0}});
         if (count_r >= period_of(rate) - 1'b1) begin
            count_r <= {`PACER_WIDTH{1'b0}};
         end else begin
            count_r <= count_r + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/adc_capture_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_capture_checker (
   // clock and reset
   input wire logic        MCLK,
   input wire logic        SRST,
   // serial bus
   input wire logic        SCL,
   input wire logic        SDA_IN,
   input wire logic        SDA_OUT,
   input wire logic        SDA_OE,
   // converter
   input wire logic        CONV_START,
   input wire logic        CONV_PORT,
   input wire logic        CONV_DONE,
   input wire logic [11:0] CONV_DATA,
   // pump, touch limit, events
   input wire logic        PUMP_ON,
   input wire logic [1:0]  TOUCH_RATE_LIMIT,
   input wire logic        IRQ_PORT0,
   input wire logic        IRQ_PORT1
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   logic busy_r;
   logic busy_nxt;
   wire  irq = IRQ_PORT0 | IRQ_PORT1;
   // converter busy as seen at the pins
   always_comb busy_nxt = CONV_START ? 1'b1 : (CONV_DONE ? 1'b0 : busy_r);
   always_ff @(posedge MCLK) busy_r <= SRST ? 1'b0 : busy_nxt;
   start_pulse_a: assert property (CONV_START |=> !CONV_START)
      else $error("conversion start longer than one cycle");
   busy_start_a: assert property (CONV_START |-> !busy_r)
      else $error("conversion started while busy");
   irq_pulse_a: assert property (irq |=> !irq)
      else $error("completion event longer than one cycle");
   irq_one_port_a: assert property (!(IRQ_PORT0 && IRQ_PORT1))
      else $error("both port events at once");
   irq_port_sel_a: assert property (irq |-> (IRQ_PORT1 == CONV_PORT))
      else $error("event on unselected port");
   irq_after_done_a: assert property (irq |-> $past(CONV_DONE && busy_r))
      else $error("event without finished conversion");
   pump_hold_a: assert property (PUMP_ON |=> PUMP_ON)
      else $error("pump switched off");
   pump_by_bus_a: assert property ($rose(PUMP_ON) |-> ##[0:20] SDA_OE)
      else $error("pump on outside a register write");
   rate_by_bus_a: assert property ($changed(TOUCH_RATE_LIMIT) |-> ##[0:20] SDA_OE)
      else $error("rate limit changed outside a register write");
   bus_stable_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
      else $error("data line changed while clock high");
   cover property (IRQ_PORT0);
   cover property (IRQ_PORT1);
   cover property ($rose(PUMP_ON));
endmodule
`default_nettype wire

// ===== tb/adc_capture_control_bench.sv
`timescale 1ns/1ps
`include "adc_capture_consts.vh"
`default_nettype none
module adc_capture_control_bench;
   localparam int LIMIT = 90000;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        conv_done = 1'b0;
   logic [11:0] conv_data = 12'h000;
   logic [11:0] conv_val = 12'hfa5;
   logic [11:0] last_data = 12'h000;
   int          fail_count = 0;
   int          n_checks = 0;
   int          n_start = 0;
   int          n_irq0 = 0;
   int          n_irq1 = 0;
   int          cyc_count = 0;
   int          conv_delay = 10;
   int          cnt = 0;
   int          per [4] = '{`RATE0_CYC, `RATE1_CYC, `RATE2_CYC, `RATE3_CYC};
   wire         scl;
   wire         sda_drv;
   wire         sda_oe;
   wire         sda = sda_drv & ~sda_oe;
   wire         conv_start;
   wire         conv_port;
   wire         pump_on;
   wire [1:0]   rate_lim;
   wire         irq0;
   wire         irq1;
   adc_capture_control adc_capture_control_inst (
      .MCLK(mclk), .SRST(srst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
      .CONV_START(conv_start), .CONV_PORT(conv_port), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
      .PUMP_ON(pump_on), .TOUCH_RATE_LIMIT(rate_lim), .IRQ_PORT0(irq0), .IRQ_PORT1(irq1)
   );
   i2c_host_model i2c_host_model_inst (.mclk(mclk), .sda(sda), .scl_drv(scl), .sda_drv(sda_drv));
   always #25 mclk = ~mclk;
   // converter: answers after conv_delay cycles, data invalid otherwise
   always @(posedge mclk) begin
      cyc_count <= cyc_count + 1;
      if (conv_start === 1'b1) n_start <= n_start + 1;
      if (irq0 === 1'b1) n_irq0 <= n_irq0 + 1;
      if (irq1 === 1'b1) n_irq1 <= n_irq1 + 1;
      if (conv_start === 1'b1) cnt <= conv_delay;
      else if (cnt != 0) cnt <= cnt - 1;
      conv_done <= (cnt == 1);
      conv_data <= (cnt == 1) ? conv_val : ~conv_val;
      if (cnt == 1) begin
         last_data <= conv_val;
         conv_val <= conv_val + 12'h2b7;
      end
      if (cyc_count == LIMIT) begin
         fail_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic cyc();
      @(posedge mclk);
      #1;
   endtask
   task automatic wc(input logic [7:0] d);
      i2c_host_model_inst.wr(`REG_CONTROL, d);
   endtask
   task automatic rc(output logic [7:0] c);
      i2c_host_model_inst.rd1(`REG_CONTROL, c);
   endtask
   task automatic rr(output logic [15:0] r);
      i2c_host_model_inst.rd2(`REG_RESULT_LO, r);
   endtask
   task automatic wait_start();
      int i;
      for (i = 0; i < 4000 && conv_start !== 1'b1; i++) cyc();
      cyc();
   endtask
   task automatic t_reset();
      logic [7:0]  c;
      logic [15:0] r;
      rc(c);
      chk("control", 16'h0032, {8'h00, c});
      rr(r);
      chk("result", 16'h0000, r);
      chk("rate_limit", 16'h0003, {14'h0, rate_lim});
      $display("test reset done");
   endtask
   task automatic pump_step(input logic [7:0] w, input logic pe, input logic [7:0] ce);
      logic [7:0] c;
      wc(w);
      chk("pump_on", {15'h0, pe}, {15'h0, pump_on});
      rc(c);
      chk("control", {8'h00, ce}, {8'h00, c});
   endtask
   task automatic t_pump();
      logic [7:0] c;
      pump_step(8'h32, 1'b0, 8'h32);
      pump_step(8'h3a, 1'b0, 8'h3a);
      pump_step(8'h3e, 1'b0, 8'h32);
      pump_step(8'h3a, 1'b0, 8'h3a);
      wc(8'h3a);
      chk("pump_on", 16'h0001, {15'h0, pump_on});
      rc(c);
      chk("unlock_field", 16'h0000, {14'h0, c[2:1]});
      $display("test pump done");
   endtask
   task automatic t_oneshot(input logic p);
      logic [7:0]  c;
      logic [15:0] r;
      int          i;
      int          a;
      int          b;
      int          s;
      conv_delay = 3000;
      a = n_irq0;
      b = n_irq1;
      s = n_start;
      wc({7'h79, p});
      chk("conv_port", {15'h0, p}, {15'h0, conv_port});
      rc(c);
      chk("busy_flag", 16'h0001, {15'h0, c[6]});
      for (i = 0; i < 5000 && n_irq0 + n_irq1 == a + b; i++) cyc();
      chk("irq_own", 16'h0001, 16'(p ? n_irq1 - b : n_irq0 - a));
      chk("irq_other", 16'h0000, 16'(p ? n_irq0 - a : n_irq1 - b));
      rc(c);
      chk("busy_clear", 16'h0000, {15'h0, c[6]});
      chk("starts", 16'h0001, 16'(n_start - s));
      rr(r);
      chk("result", {4'h0, last_data}, r);
      $display("test one-shot done");
   endtask
   task automatic t_rates();
      logic [15:0] r;
      logic [2:0]  k;
      int          t0;
      conv_delay = 10;
      for (k = 0; k < 4; k++) begin
         wc({2'b01, k[1:0], 4'h2});
         wait_start();
         wait_start();
         t0 = cyc_count;
         wait_start();
         chk("period", 16'(per[k[1:0]]), 16'(cyc_count - t0));
         chk("rate_limit", {14'h0, k[1:0]}, {14'h0, rate_lim});
      end
      wc(8'h02);
      t0 = n_start;
      repeat (2500) cyc();
      chk("stopped", 16'h0000, 16'(n_start - t0));
      rr(r);
      chk("latest", {4'h0, last_data}, r);
      $display("test continuous done");
   endtask
   // lo byte read, a new sample lands, hi byte must still match the snapshot
   task automatic t_freeze();
      logic [7:0]  b;
      logic [11:0] s;
      wc(8'h42);
      wait_start();
      repeat (20) cyc();
      s = last_data;
      i2c_host_model_inst.rd1(`REG_RESULT_LO, b);
      chk("frozen_lo", {8'h00, s[7:0]}, {8'h00, b});
      i2c_host_model_inst.rd1(`REG_RESULT_HI, b);
      chk("frozen_hi", {12'h000, s[11:8]}, {8'h00, b});
      $display("test freeze done");
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      repeat (10) @(posedge mclk);
      t_reset();
      t_pump();
      t_oneshot(1'b1);
      t_oneshot(1'b0);
      t_rates();
      t_freeze();
      close_out();
   end
endmodule
bind adc_capture_control adc_capture_checker adc_capture_checker_inst (
   .MCLK(MCLK), .SRST(SRST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .CONV_START(CONV_START), .CONV_PORT(CONV_PORT), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
   .PUMP_ON(PUMP_ON), .TOUCH_RATE_LIMIT(TOUCH_RATE_LIMIT), .IRQ_PORT0(IRQ_PORT0), .IRQ_PORT1(IRQ_PORT1)
);
`default_nettype wire

// ===== tb/i2c_host_model.sv
`timescale 1ns/1ps
`include "adc_capture_consts.vh"
`default_nettype none
module i2c_host_model (
   // clock and bus line
   input  wire logic mclk,
   input  wire logic sda,
   // driven levels, low pulls the line
   output var logic  scl_drv,
   output var logic  sda_drv
);
   localparam int Q = 8;
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic wq();
      repeat (Q) @(posedge mclk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      wq();
      scl_drv <= 1'b1;
      wq();
      r = sda;
      wq();
      scl_drv <= 1'b0;
      wq();
   endtask
   task automatic start();
      sda_drv <= 1'b1;
      wq();
      scl_drv <= 1'b1;
      wq();
      sda_drv <= 1'b0;
      wq();
      scl_drv <= 1'b0;
      wq();
   endtask
   task automatic stop();
      sda_drv <= 1'b0;
      wq();
      scl_drv <= 1'b1;
      wq();
      sda_drv <= 1'b1;
      wq();
   endtask
   task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ak, r);
   endtask
   // one write is one transaction
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] q;
      start();
      byte_io({`DEV_ADDR, 1'b0}, 1'b1, q);
      byte_io(p, 1'b1, q);
      byte_io(d, 1'b1, q);
      stop();
   endtask
   task automatic head(input logic [7:0] p);
      logic [7:0] q;
      start();
      byte_io({`DEV_ADDR, 1'b0}, 1'b1, q);
      byte_io(p, 1'b1, q);
      start();
      byte_io({`DEV_ADDR, 1'b1}, 1'b1, q);
   endtask
   task automatic rd1(input logic [7:0] p, output logic [7:0] v);
      head(p);
      byte_io(8'hff, 1'b1, v);
      stop();
   endtask
   task automatic rd2(input logic [7:0] p, output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      head(p);
      byte_io(8'hff, 1'b0, lo);
      byte_io(8'hff, 1'b1, hi);
      stop();
      v = {hi, lo};
   endtask
endmodule
`default_nettype wire
